// ==== common/lsr_pkg.sv ====
// Purpose: Shared constants and carriers for the lock status readback and write lock block.
// Assumes: 24-bit serial frames, MSB first: read flag, two width bits, 13 address bits, 8 data bits.
// Notes: Offsets are the serial register addresses of the device.

`default_nettype none

package lsr_pkg;

   // ----------------------------------------
   // Frame layout
   // ----------------------------------------
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam logic [4:0] CNT_HEADER_DONE = 5'h10;
   localparam logic [4:0] CNT_FRAME_DONE = 5'h18;
   localparam int HDR_RD_BIT = 15;
   localparam int FRM_RD_BIT = 23;
   localparam int FRM_ADDR_LSB = 8;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [12:0] ADDR_VCO_OPT2 = 13'h017D;
   localparam logic [12:0] ADDR_LOOP1_STAT = 13'h0182;
   localparam logic [12:0] ADDR_LOOP2_STAT = 13'h0183;
   localparam logic [12:0] ADDR_SEL_LOSS = 13'h0184;
   localparam logic [12:0] ADDR_DAC_LOW = 13'h0185;
   localparam logic [12:0] ADDR_HOLDOVER = 13'h0188;
   localparam logic [12:0] ADDR_KEY_HIGH = 13'h1FFD;
   localparam logic [12:0] ADDR_KEY_MID = 13'h1FFE;
   localparam logic [12:0] ADDR_KEY_LOW = 13'h1FFF;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_CLEAR = 0;
   localparam int BIT_LIVE = 1;
   localparam int BIT_STICKY = 2;
   localparam int BIT_LOS0 = 0;
   localparam int BIT_LOS1 = 1;
   localparam int BIT_SEL0 = 3;
   localparam int BIT_SEL1 = 4;
   localparam int BIT_SEL2 = 5;
   localparam int BIT_DAC_HI_LSB = 6;
   localparam int BIT_DAC_HI_MSB = 7;
   localparam int BIT_HOLDOVER = 4;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] KEY_HIGH_RST = 8'h00;
   localparam logic [7:0] KEY_MID_RST = 8'h00;
   localparam logic [7:0] KEY_LOW_RST = 8'h53;
   localparam logic [23:0] KEY_UNLOCK = {KEY_HIGH_RST, KEY_MID_RST, KEY_LOW_RST};
   localparam logic [9:0] DAC_RST = 10'h200;
   localparam logic [7:0] OPT2_RST = 8'h00;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic loop1_lock_live;
      logic loop2_lock_live;
      logic ref2_selected;
      logic ref1_selected;
      logic ref0_selected;
      logic ref1_signal_lost;
      logic ref0_signal_lost;
      logic holdover_active;
      logic [9:0] holdover_dac_readback;
   } lsr_status_t;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic sdi;
   } lsr_link_t;

   localparam lsr_link_t LINK_IDLE = '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};

endpackage : lsr_pkg

`default_nettype wire

// ==== hdl/lsr_lock_status.sv ====
// Purpose: Lock status readback, reference and holdover readback, and register write lock.
// Assumes: Serial clock, select and data arrive asynchronously and are sampled by sys_clk_i.
// Notes: Writes to addresses this block does not own are forwarded on the write port when allowed.
// Notes on behaviour
// - Loop-one sticky lost flag sets on a falling loop-one lock indicator.
// - Loop-one clear bit at one holds the sticky flag at zero.
// - Loop-two sticky lost flag sets on a falling loop-two lock indicator.
// - Loop-two clear bit at one holds its sticky flag at zero.
// - Loop-one status bit one reads the live loop-one lock level.
// - Loop-two status bit one reads the live loop-two lock level.
// - Selection register bits five to three show which reference feeds loop one.
// - Selection register bits one and zero show loss of signal on references one, zero.
// - DAC value top two bits sit in bits seven, six; low byte next register.
// - DAC readback is 512 after reset and may change once loop one locks.
// - Holdover register bit four shows whether the device is in holdover.
// - While locked, only the three key registers accept writes.
// - Key registers are write-only and read back as zero.
// - Unlocked only when key is zero, zero, 83; anything else locks.

`timescale 1ns/1ns
`default_nettype none

module lsr_lock_status (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // Serial register interface
   input wire logic spi_sclk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_sdi_i,
   output logic spi_sdo_o,
   output logic spi_sdo_oe_n_o,
   // Indicators from the loops, input selector and holdover logic
   input wire lsr_pkg::lsr_status_t status_i,
   // Register contents and write port to the rest of the device
   output logic [7:0] vco_opt_setting_two_o,
   output logic regs_unlocked_o,
   output logic reg_wr_o,
   output logic [12:0] reg_wr_addr_o,
   output logic [7:0] reg_wr_data_o
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      lsr_pkg::lsr_status_t stat_s1;
      lsr_pkg::lsr_status_t stat_s2;
      lsr_pkg::lsr_link_t link_s1;
      lsr_pkg::lsr_link_t link_s2;
      logic sclk_d;
      logic loop1_live_d;
      logic loop2_live_d;
      logic [4:0] bit_cnt;
      logic [23:0] shift_in;
      logic [7:0] shift_out;
      logic rd_phase;
      logic rd_load;
      logic sdo;
      logic sdo_oe_n;
      logic loop1_lost_lock_clear;
      logic loop2_lost_lock_clear;
      logic loop1_lost_lock_sticky;
      logic loop2_lost_lock_sticky;
      logic dac_track;
      logic [9:0] dac;
      logic [7:0] opt2;
      logic [23:0] key;
      logic unlocked;
      logic wr;
      logic [12:0] wr_addr;
      logic [7:0] wr_data;
   } lsr_state_t;

   localparam lsr_state_t STATE_RST = '{
      link_s1: lsr_pkg::LINK_IDLE,
      link_s2: lsr_pkg::LINK_IDLE,
      sdo_oe_n: 1'b1,
      dac: lsr_pkg::DAC_RST,
      opt2: lsr_pkg::OPT2_RST,
      key: lsr_pkg::KEY_UNLOCK,
      unlocked: 1'b1,
      default: '0
   };

   lsr_state_t s_r;
   lsr_state_t s_nxt;

   // ----------------------------------------
   // Readback
   // ----------------------------------------
   function automatic logic [7:0] read_byte(input lsr_state_t st, input logic [12:0] addr);
      logic [7:0] b;
      b = '0;
      unique case (addr)
         lsr_pkg::ADDR_VCO_OPT2: b = st.opt2;
         lsr_pkg::ADDR_LOOP1_STAT: begin
            b[lsr_pkg::BIT_CLEAR] = st.loop1_lost_lock_clear;
            b[lsr_pkg::BIT_LIVE] = st.stat_s2.loop1_lock_live;
            b[lsr_pkg::BIT_STICKY] = st.loop1_lost_lock_sticky;
         end
         lsr_pkg::ADDR_LOOP2_STAT: begin
            b[lsr_pkg::BIT_CLEAR] = st.loop2_lost_lock_clear;
            b[lsr_pkg::BIT_LIVE] = st.stat_s2.loop2_lock_live;
            b[lsr_pkg::BIT_STICKY] = st.loop2_lost_lock_sticky;
         end
         lsr_pkg::ADDR_SEL_LOSS: begin
            b[lsr_pkg::BIT_SEL2] = st.stat_s2.ref2_selected;
            b[lsr_pkg::BIT_SEL1] = st.stat_s2.ref1_selected;
            b[lsr_pkg::BIT_SEL0] = st.stat_s2.ref0_selected;
            b[lsr_pkg::BIT_LOS1] = st.stat_s2.ref1_signal_lost;
            b[lsr_pkg::BIT_LOS0] = st.stat_s2.ref0_signal_lost;
            b[lsr_pkg::BIT_DAC_HI_MSB:lsr_pkg::BIT_DAC_HI_LSB] = st.dac[9:8];
         end
         lsr_pkg::ADDR_DAC_LOW: b = st.dac[7:0];
         lsr_pkg::ADDR_HOLDOVER: b[lsr_pkg::BIT_HOLDOVER] = st.stat_s2.holdover_active;
         default: b = '0;
      endcase
      return b;
   endfunction : read_byte

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic sclk_rise;
      logic sclk_fall;
      logic [4:0] cnt_inc;
      logic [12:0] waddr;
      logic [7:0] wdata;
      logic key_addr;
      sclk_rise = 1'b0;
      sclk_fall = 1'b0;
      cnt_inc = '0;
      waddr = '0;
      wdata = '0;
      key_addr = 1'b0;
      s_nxt = s_r;
      s_nxt.stat_s1 = status_i;
      s_nxt.stat_s2 = s_r.stat_s1;
      s_nxt.link_s1 = '{sclk: spi_sclk_i, cs_n: spi_cs_n_i, sdi: spi_sdi_i};
      s_nxt.link_s2 = s_r.link_s1;
      s_nxt.sclk_d = s_r.link_s2.sclk;
      s_nxt.loop1_live_d = s_r.stat_s2.loop1_lock_live;
      s_nxt.loop2_live_d = s_r.stat_s2.loop2_lock_live;
      s_nxt.wr = 1'b0;
      s_nxt.rd_load = 1'b0;
      sclk_rise = s_r.link_s2.sclk & ~s_r.sclk_d;
      sclk_fall = ~s_r.link_s2.sclk & s_r.sclk_d;
      cnt_inc = s_r.bit_cnt + 5'h01;

      // Frame capture; the select going high aborts any partial frame.
      if (s_r.link_s2.cs_n) begin
         s_nxt.bit_cnt = '0;
         s_nxt.rd_phase = 1'b0;
         s_nxt.sdo_oe_n = 1'b1;
      end else if (sclk_rise && s_r.bit_cnt != lsr_pkg::CNT_FRAME_DONE) begin
         s_nxt.shift_in = {s_r.shift_in[22:0], s_r.link_s2.sdi};
         s_nxt.bit_cnt = cnt_inc;
         if (cnt_inc == lsr_pkg::CNT_HEADER_DONE && s_nxt.shift_in[lsr_pkg::HDR_RD_BIT]) begin
            s_nxt.shift_out = read_byte(s_r, s_nxt.shift_in[12:0]);
            s_nxt.rd_phase = 1'b1;
            s_nxt.rd_load = 1'b1;
         end
         if (cnt_inc == lsr_pkg::CNT_FRAME_DONE && !s_nxt.shift_in[lsr_pkg::FRM_RD_BIT]) begin
            waddr = s_nxt.shift_in[lsr_pkg::FRM_ADDR_LSB +: lsr_pkg::ADDR_W];
            wdata = s_nxt.shift_in[7:0];
            key_addr = waddr == lsr_pkg::ADDR_KEY_HIGH || waddr == lsr_pkg::ADDR_KEY_MID
               || waddr == lsr_pkg::ADDR_KEY_LOW;
            if (s_r.unlocked || key_addr) begin
               unique case (waddr)
                  lsr_pkg::ADDR_VCO_OPT2: s_nxt.opt2 = wdata;
                  lsr_pkg::ADDR_LOOP1_STAT: s_nxt.loop1_lost_lock_clear = wdata[lsr_pkg::BIT_CLEAR];
                  lsr_pkg::ADDR_LOOP2_STAT: s_nxt.loop2_lost_lock_clear = wdata[lsr_pkg::BIT_CLEAR];
                  lsr_pkg::ADDR_SEL_LOSS, lsr_pkg::ADDR_DAC_LOW, lsr_pkg::ADDR_HOLDOVER: begin
                  end
                  lsr_pkg::ADDR_KEY_HIGH: s_nxt.key[23:16] = wdata;
                  lsr_pkg::ADDR_KEY_MID: s_nxt.key[15:8] = wdata;
                  lsr_pkg::ADDR_KEY_LOW: s_nxt.key[7:0] = wdata;
                  default: begin
                     s_nxt.wr = 1'b1;
                     s_nxt.wr_addr = waddr;
                     s_nxt.wr_data = wdata;
                  end
               endcase
            end
         end
      end else if (sclk_fall && s_r.rd_phase) begin
         // Read data changes on the falling edge so it is stable at the host's rising edge.
         s_nxt.sdo = s_r.shift_out[7];
         s_nxt.shift_out = {s_r.shift_out[6:0], 1'b0};
         s_nxt.sdo_oe_n = 1'b0;
      end

      // Sticky lost-lock flags; a held clear wins over a falling edge.
      if (s_nxt.loop1_lost_lock_clear) begin
         s_nxt.loop1_lost_lock_sticky = 1'b0;
      end else if (s_r.loop1_live_d && !s_r.stat_s2.loop1_lock_live) begin
         s_nxt.loop1_lost_lock_sticky = 1'b1;
      end
      if (s_nxt.loop2_lost_lock_clear) begin
         s_nxt.loop2_lost_lock_sticky = 1'b0;
      end else if (s_r.loop2_live_d && !s_r.stat_s2.loop2_lock_live) begin
         s_nxt.loop2_lost_lock_sticky = 1'b1;
      end

      // DAC readback stays at its reset value until loop one first locks.
      if (s_r.stat_s2.loop1_lock_live) begin
         s_nxt.dac_track = 1'b1;
      end
      if (s_r.dac_track) begin
         s_nxt.dac = s_r.stat_s2.holdover_dac_readback;
      end

      s_nxt.unlocked = s_nxt.key == lsr_pkg::KEY_UNLOCK;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         s_r <= STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign spi_sdo_o = s_r.sdo;
   assign spi_sdo_oe_n_o = s_r.sdo_oe_n;
   assign vco_opt_setting_two_o = s_r.opt2;
   assign regs_unlocked_o = s_r.unlocked;
   assign reg_wr_o = s_r.wr;
   assign reg_wr_addr_o = s_r.wr_addr;
   assign reg_wr_data_o = s_r.wr_data;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);

   sequence loop1_fall_armed_s;
      $fell(s_r.stat_s2.loop1_lock_live) && !s_nxt.loop1_lost_lock_clear;
   endsequence

   sequence loop2_fall_armed_s;
      $fell(s_r.stat_s2.loop2_lock_live) && !s_nxt.loop2_lost_lock_clear;
   endsequence

   sequence locked_write_s;
      !s_r.unlocked && !s_nxt.unlocked;
   endsequence

   AST_LOOP1_FALL_SETS: assert property (loop1_fall_armed_s |=> s_r.loop1_lost_lock_sticky)
      else $error("Loop one sticky flag missed a falling lock edge.");

   AST_LOOP1_CLEAR_HOLDS: assert property (s_r.loop1_lost_lock_clear |-> !s_r.loop1_lost_lock_sticky)
      else $error("Loop one sticky flag set while its clear is held.");

   AST_LOOP2_FALL_SETS: assert property (loop2_fall_armed_s |=> s_r.loop2_lost_lock_sticky)
      else $error("Loop two sticky flag missed a falling lock edge.");

   AST_LOOP2_CLEAR_HOLDS: assert property (s_r.loop2_lost_lock_clear |-> !s_r.loop2_lost_lock_sticky)
      else $error("Loop two sticky flag set while its clear is held.");

   AST_LOCKED_NO_WRITE: assert property (locked_write_s |=> !s_r.wr && $stable(s_r.opt2)
      && $stable(s_r.loop1_lost_lock_clear) && $stable(s_r.loop2_lost_lock_clear))
      else $error("A register changed while writes were locked.");

   AST_UNLOCK_KEY: assert property (s_r.unlocked == (s_r.key == lsr_pkg::KEY_UNLOCK))
      else $error("Lock state disagrees with the stored key.");

   AST_DAC_RESET_VALUE: assert property (!s_r.dac_track |-> s_r.dac == lsr_pkg::DAC_RST)
      else $error("DAC readback left its reset value before loop one locked.");

   AST_KEY_READS_ZERO: assert property (s_r.rd_load && (s_r.shift_in[12:0] == lsr_pkg::ADDR_KEY_HIGH
      || s_r.shift_in[12:0] == lsr_pkg::ADDR_KEY_MID || s_r.shift_in[12:0] == lsr_pkg::ADDR_KEY_LOW)
      |-> s_r.shift_out == '0)
      else $error("A key register returned nonzero read data.");

   AST_HOLDOVER_READ: assert property (s_r.rd_load && s_r.shift_in[12:0] == lsr_pkg::ADDR_HOLDOVER
      |-> s_r.shift_out[lsr_pkg::BIT_HOLDOVER] == $past(s_r.stat_s2.holdover_active))
      else $error("Holdover readback does not match the holdover indicator.");

   // ----------------------------------------
   // Sticky flag set, readback and reset checks
   // ----------------------------------------
   // The header of a read frame has just loaded the byte for this address.
   sequence read_load_s(logic [12:0] addr);
      s_r.rd_load && s_r.shift_in[12:0] == addr;
   endsequence

   // The synchronised lock level was high two samples back and low one sample back.
   sequence loop1_fell_before_s;
      $past(s_r.stat_s2.loop1_lock_live, 2) && !$past(s_r.stat_s2.loop1_lock_live);
   endsequence

   sequence loop2_fell_before_s;
      $past(s_r.stat_s2.loop2_lock_live, 2) && !$past(s_r.stat_s2.loop2_lock_live);
   endsequence

   AST_LOOP1_SET_NEEDS_FALL: assert property ($rose(s_r.loop1_lost_lock_sticky) |-> loop1_fell_before_s)
      else $error("Loop one sticky flag set without a falling lock edge.");

   AST_LOOP2_SET_NEEDS_FALL: assert property ($rose(s_r.loop2_lost_lock_sticky) |-> loop2_fell_before_s)
      else $error("Loop two sticky flag set without a falling lock edge.");

   AST_LIVE1_READ: assert property (read_load_s(lsr_pkg::ADDR_LOOP1_STAT)
      |-> s_r.shift_out[lsr_pkg::BIT_LIVE] == $past(s_r.stat_s2.loop1_lock_live))
      else $error("Loop one live lock readback is wrong.");

   AST_LIVE2_READ: assert property (read_load_s(lsr_pkg::ADDR_LOOP2_STAT)
      |-> s_r.shift_out[lsr_pkg::BIT_LIVE] == $past(s_r.stat_s2.loop2_lock_live))
      else $error("Loop two live lock readback is wrong.");

   AST_SELECT_READ: assert property (read_load_s(lsr_pkg::ADDR_SEL_LOSS)
      |-> s_r.shift_out[lsr_pkg::BIT_SEL2:lsr_pkg::BIT_SEL0] == $past({s_r.stat_s2.ref2_selected,
      s_r.stat_s2.ref1_selected, s_r.stat_s2.ref0_selected}))
      else $error("Reference selection readback is wrong.");

   AST_LOSS_READ: assert property (read_load_s(lsr_pkg::ADDR_SEL_LOSS)
      |-> s_r.shift_out[lsr_pkg::BIT_LOS1:lsr_pkg::BIT_LOS0] == $past({s_r.stat_s2.ref1_signal_lost,
      s_r.stat_s2.ref0_signal_lost}))
      else $error("Loss of signal readback is wrong.");

   AST_DAC_HIGH_READ: assert property (read_load_s(lsr_pkg::ADDR_SEL_LOSS)
      |-> s_r.shift_out[lsr_pkg::BIT_DAC_HI_MSB:lsr_pkg::BIT_DAC_HI_LSB] == $past(s_r.dac[9:8]))
      else $error("DAC top bits readback is wrong.");

   AST_DAC_LOW_READ: assert property (read_load_s(lsr_pkg::ADDR_DAC_LOW)
      |-> s_r.shift_out == $past(s_r.dac[7:0]))
      else $error("DAC low byte readback is wrong.");

   AST_RESET_UNLOCKED: assert property ($fell(reset_i) |-> s_r.unlocked && s_r.key == lsr_pkg::KEY_UNLOCK
      && s_r.dac == lsr_pkg::DAC_RST)
      else $error("Key, lock state or DAC readback wrong after reset.");

endmodule : lsr_lock_status

`default_nettype wire

// ==== sim/lsr_host_model.sv ====
// Purpose: Host on the serial register link of the lock status block.
// Assumes: 160 ns serial clock period, started at a phase unrelated to the system clock.
// Notes: The serial clock stands still outside frames; released data lines show the inverse level.

`timescale 1ns/1ns
`default_nettype none

module lsr_host_model (
   // Serial link
   output var lsr_pkg::lsr_link_t link_o,
   input wire logic sdo_i,
   input wire logic sdo_oe_n_i
);

   initial link_o = lsr_pkg::LINK_IDLE;

   // One 24 bit frame, MSB first; read data is taken on rising clock edges 17 to 24.
   task automatic frame(input logic rd, input logic [12:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
      logic [23:0] word;
      word = {rd, 2'b00, addr, wdata};
      rdata = 8'h00;
      #37;
      link_o.cs_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         link_o.sdi = (rd && i < 8) ? ~link_o.sdi : word[i];
         #80;
         link_o.sclk = 1'b1;
         if (i < 8) begin
            rdata[i] = sdo_oe_n_i ? 1'bx : sdo_i;
         end
         #80;
         link_o.sclk = 1'b0;
      end
      #80;
      link_o.cs_n = 1'b1;
      link_o.sdi = ~link_o.sdi;
      #200;
   endtask : frame

endmodule : lsr_host_model

`default_nettype wire

// ==== sim/lsr_lock_status_bench.sv ====
// Purpose: Self-checking bench for the lock status readback and write lock block.
// Assumes: Status inputs change only between frames.
// Notes: Clear bits stay set during the table so sticky flags do not disturb it.

`timescale 1ns/1ns
`default_nettype none

module lsr_lock_status_bench;

   typedef struct packed {
      lsr_pkg::lsr_status_t st;
      logic [39:0] exp;
   } lsr_row_t;

   // ----------------------------------------
   // Signals and table
   // ----------------------------------------
   localparam lsr_row_t rows[3] = '{'{18'h293A5, 40'h0301E2A500}, '{18'h14C5A, 40'h0103115A10},
                                    '{18'h33AC3, 40'h03038BC300}};
   localparam logic [12:0] addrs[5] = '{lsr_pkg::ADDR_LOOP1_STAT, lsr_pkg::ADDR_LOOP2_STAT,
                                        lsr_pkg::ADDR_SEL_LOSS, lsr_pkg::ADDR_DAC_LOW, lsr_pkg::ADDR_HOLDOVER};
   localparam logic [23:0] keys[5] = '{24'h010053, 24'h000153, 24'h000052, 24'h000054, 24'h000053};
   logic sys_clk = 1'b0;
   logic reset;
   lsr_pkg::lsr_status_t st;
   lsr_pkg::lsr_link_t link;
   logic sdo, sdo_oe_n, unlocked, reg_wr;
   logic [7:0] opt2, wr_data;
   logic [12:0] wr_addr;
   int errors = 0;
   int checks_done = 0;
   int wr_pulses = 0;

   always #5 sys_clk = ~sys_clk;
   always @(negedge sys_clk) begin
      if (reg_wr === 1'b1) begin
         wr_pulses++;
      end
   end

   lsr_lock_status lsr_lock_status_i (.sys_clk_i(sys_clk), .reset_i(reset), .spi_sclk_i(link.sclk),
      .spi_cs_n_i(link.cs_n), .spi_sdi_i(link.sdi), .spi_sdo_o(sdo), .spi_sdo_oe_n_o(sdo_oe_n),
      .status_i(st), .vco_opt_setting_two_o(opt2), .regs_unlocked_o(unlocked), .reg_wr_o(reg_wr),
      .reg_wr_addr_o(wr_addr), .reg_wr_data_o(wr_data));
   lsr_host_model lsr_host_model_i (.link_o(link), .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [12:0] addr, input logic [7:0] data);
      logic [7:0] unused;
      lsr_host_model_i.frame(1'b0, addr, data, unused);
   endtask : wr

   task automatic rd_chk(input logic [12:0] addr, input logic [7:0] exp);
      logic [7:0] v;
      lsr_host_model_i.frame(1'b1, addr, 8'h00, v);
      check("read data", 24'(v), 24'(exp));
   endtask : rd_chk

   task automatic set_lock(input int n, input logic v);
      @(posedge sys_clk);
      if (n == 0) begin
         st.loop1_lock_live <= v;
      end else begin
         st.loop2_lock_live <= v;
      end
      repeat (6) @(posedge sys_clk);
   endtask : set_lock

   task automatic do_reset;
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask : do_reset

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      reset <= 1'b1;
      st <= '0;
      do_reset();
      wr(lsr_pkg::ADDR_LOOP1_STAT, 8'h01);
      wr(lsr_pkg::ADDR_LOOP2_STAT, 8'h01);
      for (int r = 0; r < 3; r++) begin
         @(posedge sys_clk);
         st <= rows[r].st;
         repeat (6) @(posedge sys_clk);
         for (int k = 0; k < 5; k++) begin
            rd_chk(addrs[k], rows[r].exp[39 - 8 * k -: 8]);
         end
      end
      // Sticky flags: held while clear is set, not set on release, set on a later fall.
      for (int n = 0; n < 2; n++) begin
         set_lock(n, 1'b0);
         rd_chk(addrs[n], 8'h01);
         wr(addrs[n], 8'h00);
         rd_chk(addrs[n], 8'h00);
         set_lock(n, 1'b1);
         set_lock(n, 1'b0);
         rd_chk(addrs[n], 8'h04);
         wr(addrs[n], 8'h01);
         rd_chk(addrs[n], 8'h01);
         wr(addrs[n], 8'h00);
         rd_chk(addrs[n], 8'h00);
      end
      wr(lsr_pkg::ADDR_VCO_OPT2, 8'h33);
      wr(13'h0100, 8'h5A);
      check("opt2", 24'(opt2), 24'h000033);
      check("write addr", 24'(wr_addr), 24'h000100);
      check("write data", 24'(wr_data), 24'h00005A);
      check("write pulses", 24'(wr_pulses), 24'h000001);
      for (int i = 0; i < 5; i++) begin
         wr(lsr_pkg::ADDR_KEY_HIGH, keys[i][23:16]);
         wr(lsr_pkg::ADDR_KEY_MID, keys[i][15:8]);
         wr(lsr_pkg::ADDR_KEY_LOW, keys[i][7:0]);
         check("unlocked", 24'(unlocked), 24'(i == 4));
         wr(lsr_pkg::ADDR_VCO_OPT2, 8'h77);
         wr(13'h0101, 8'h99);
         check("opt2 locked", 24'(opt2), (i == 4) ? 24'h000077 : 24'h000033);
         check("write pulses", 24'(wr_pulses), 24'(1 + (i == 4)));
      end
      wr(lsr_pkg::ADDR_KEY_HIGH, 8'h05);
      check("unlocked", 24'(unlocked), 24'h000000);
      @(posedge sys_clk);
      st <= 18'h000FF;
      do_reset();
      check("unlocked", 24'(unlocked), 24'h000001);
      check("opt2 reset", 24'(opt2), 24'h000000);
      rd_chk(lsr_pkg::ADDR_SEL_LOSS, 8'h80);
      rd_chk(lsr_pkg::ADDR_DAC_LOW, 8'h00);
      rd_chk(lsr_pkg::ADDR_KEY_LOW, 8'h00);
      tally_and_finish();
   end

   initial begin
      repeat (60000) @(posedge sys_clk);
      errors++;
      tally_and_finish();
   end

endmodule : lsr_lock_status_bench

`default_nettype wire
